// *** hdl/pecg_pkg.sv ***
// package: register map, field positions and reset values of the enables
`default_nettype none
package pecg_pkg;
	// register byte addresses on the system bus
	localparam logic [31:0] PECG_FN_ONE_ADDR   = 32'h40000028;
	localparam logic [31:0] PECG_FN_TWO_ADDR   = 32'h4000002C;
	localparam logic [31:0] PECG_CLK_ONE_ADDR  = 32'h40000030;
	// first register group: timers, io ports, dma
	localparam int PECG_TMR_NINE_BIT   = 25;
	localparam int PECG_TMR_EIGHT_BIT  = 24;
	localparam int PECG_TMR_LOW_MSB    = 19;
	localparam int PECG_TMR_LOW_LSB    = 16;
	localparam int PECG_PORT_D_BIT     = 11;
	localparam int PECG_PORT_A_BIT     = 8;
	localparam int PECG_DMA_BIT        = 4;
	localparam int PECG_RSVD_MSB       = 3;
	// second register group: analog, converters, pwm, serial
	localparam int PECG_AFE_BIT        = 23;
	localparam int PECG_CONV_MSB       = 22;
	localparam int PECG_CONV_LSB       = 20;
	localparam int PECG_MPWM_ONE_BIT   = 17;
	localparam int PECG_MPWM_ZERO_BIT  = 16;
	localparam int PECG_UART_MSB       = 11;
	localparam int PECG_UART_LSB       = 8;
	localparam int PECG_I2C_ONE_BIT    = 5;
	localparam int PECG_I2C_ZERO_BIT   = 4;
	localparam int PECG_SPI_ONE_BIT    = 1;
	localparam int PECG_SPI_ZERO_BIT   = 0;
	// value after reset: every implemented enable set
	localparam logic [31:0] PECG_RST_ALL_ON  = 32'hFFFFFFFF;
	// axi response codes
	localparam logic [1:0]  PECG_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  PECG_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** hdl/pecg_clk_gate.sv ***
// glitch-free clock gate for one peripheral clock
`default_nettype none
module pecg_clk_gate (
	// source clock
	input  wire logic clk_i,
	// enable from the clock-gate register, core clock domain
	input  wire logic en_i,
	// gated clock to the peripheral
	output logic      gclk_o
);
	logic en_low;  // enable held across the high phase

	// enable is taken only on the falling edge, so it changes while
	// the source clock is low and no pulse is ever cut short
	always_ff @(negedge clk_i) begin
		en_low <= en_i;
	end

	// and-gate: clock passes only while the low-phase enable is set
	assign gclk_o = clk_i & en_low;
endmodule
`default_nettype wire

// *** hdl/pecg_rst_hold.sv ***
// per-peripheral reset outputs driven from the function enables
`default_nettype none
module pecg_rst_hold #(
	parameter int WIDTH = 32  // peripherals in the group
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	// function enables, one bit per peripheral
	input  wire logic [WIDTH-1:0] fn_en_i,
	// active-low peripheral resets
	output logic      [WIDTH-1:0] periph_rst_n_o
);
	// one reset flop per peripheral
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			// held in reset during system reset and while enable is clear
			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					periph_rst_n_o[gi] <= 1'b0;
				end else begin
					periph_rst_n_o[gi] <= fn_en_i[gi];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** hdl/pecg_top.sv ***
// peripheral function-enable and clock-gate control with axi4-lite slave
//
// Summary of operation
// - writing one to function bit releases peripheral
// - peripheral held in reset until enabled
// - all peripherals enabled after reset
// - writing zero disables and resets peripheral
// - timer enables at bits 25,24,19..16
// - io port enables at bits 11..8
// - dma at bit 4, bits 3..0 reserved
// - analog front end 23, converters 22..20
// - motor pwm enables at bits 17, 16
// - uart enables at bits 11..8
// - i2c at 5,4; spi at 1,0
// - second function register implements bits 23..0 only
// - writing one to clock bit starts clock
// - writing zero to clock bit stops clock
// - clock register uses first register's layout
`default_nettype none
module pecg_top
	import pecg_pkg::*;
(
	// clock and synchronous reset
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	// axi4-lite write address channel
	input  wire logic [31:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	// axi4-lite write data channel
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	// axi4-lite write response channel
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// axi4-lite read address channel
	input  wire logic [31:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	// axi4-lite read data channel
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// active-low peripheral resets, bit-aligned with the registers
	output logic [31:0]      fn_one_rst_n_o,
	output logic [31:0]      fn_two_rst_n_o,
	// gated peripheral clocks, bit-aligned with the clock register
	output logic [31:0]      gated_clk_one_o
);
	import pecg_pkg::*;

	// the enable registers sit on the system bus; each peripheral sees
	// its function enable as an active-low reset one edge later, and
	// its clock enable as a gated copy of the core clock from the next
	// falling edge on

	// implemented-bit masks, built from the field positions
	logic [31:0] mask_one;   // timers, io ports, dma
	logic [31:0] mask_two;   // analog, converters, pwm, serial

	// first group layout, shared by function and clock registers
	always_comb begin
		mask_one = 32'h00000000;
		mask_one[PECG_TMR_NINE_BIT]                   = 1'b1;
		mask_one[PECG_TMR_EIGHT_BIT]                  = 1'b1;
		mask_one[PECG_TMR_LOW_MSB:PECG_TMR_LOW_LSB]   = 4'hF;
		mask_one[PECG_PORT_D_BIT:PECG_PORT_A_BIT]     = 4'hF;
		mask_one[PECG_DMA_BIT]                        = 1'b1;
		mask_one[PECG_RSVD_MSB:0]                     = 4'h0;
	end

	// second group layout
	always_comb begin
		mask_two = 32'h00000000;
		mask_two[PECG_AFE_BIT]                        = 1'b1;
		mask_two[PECG_CONV_MSB:PECG_CONV_LSB]         = 3'h7;
		mask_two[PECG_MPWM_ONE_BIT]                   = 1'b1;
		mask_two[PECG_MPWM_ZERO_BIT]                  = 1'b1;
		mask_two[PECG_UART_MSB:PECG_UART_LSB]         = 4'hF;
		mask_two[PECG_I2C_ONE_BIT]                    = 1'b1;
		mask_two[PECG_I2C_ZERO_BIT]                   = 1'b1;
		mask_two[PECG_SPI_ONE_BIT]                    = 1'b1;
		mask_two[PECG_SPI_ZERO_BIT]                   = 1'b1;
	end

	// software-visible enable registers
	logic [31:0] peripheral_function_enable_one;  // function enables 1
	logic [31:0] peripheral_function_enable_two;  // function enables 2
	logic [31:0] peripheral_clock_gate_one;       // clock enables 1

	// write channel holding state
	logic        aw_full;    // write address taken, not yet used
	logic        w_full;     // write data taken, not yet used
	logic [31:0] aw_addr;    // held write address
	logic [31:0] w_data;     // held write data
	logic [3:0]  w_strb;     // held byte strobes

	// handshakes on each channel
	wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
	wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
	wire ar_take = s_axi_arvalid_i & s_axi_arready_o;

	// address and data may arrive in either order; each is parked in
	// its own holding slot and the write waits for the later of the two
	// write commits once both address and data are held
	wire do_write = aw_full & w_full;

	// write address decode
	wire wsel_fn_one  = (aw_addr == PECG_FN_ONE_ADDR);
	wire wsel_fn_two  = (aw_addr == PECG_FN_TWO_ADDR);
	wire wsel_clk_one = (aw_addr == PECG_CLK_ONE_ADDR);
	wire wsel_hit     = wsel_fn_one | wsel_fn_two | wsel_clk_one;

	// byte strobes widened to a bit mask
	wire [31:0] strb_bits = {{8{w_strb[3]}}, {8{w_strb[2]}},
		{8{w_strb[1]}}, {8{w_strb[0]}}};

	// bits each write may change: strobed and implemented only
	wire [31:0] wr_mask_one = strb_bits & mask_one;
	wire [31:0] wr_mask_two = strb_bits & mask_two;

	// a clear bit in a strobed lane drops the enable at once, which
	// puts the peripheral back into reset at the next edge
	// merged values: ones set enables, zeros clear them
	wire [31:0] merged_fn_one = (peripheral_function_enable_one
		& ~wr_mask_one) | (w_data & wr_mask_one);
	wire [31:0] merged_fn_two = (peripheral_function_enable_two
		& ~wr_mask_two) | (w_data & wr_mask_two);
	wire [31:0] merged_clk_one = (peripheral_clock_gate_one
		& ~wr_mask_one) | (w_data & wr_mask_one);

	// next state of the write path
	wire next_aw_full = (aw_full & ~do_write) | aw_take;
	wire next_w_full  = (w_full & ~do_write) | w_take;
	wire next_bvalid  = (s_axi_bvalid_o & ~s_axi_bready_i) | do_write;

	// read address decode
	wire rsel_fn_one  = (s_axi_araddr_i == PECG_FN_ONE_ADDR);
	wire rsel_fn_two  = (s_axi_araddr_i == PECG_FN_TWO_ADDR);
	wire rsel_clk_one = (s_axi_araddr_i == PECG_CLK_ONE_ADDR);
	wire rsel_hit     = rsel_fn_one | rsel_fn_two | rsel_clk_one;

	// the read address is decoded straight from the bus; the answer is
	// loaded only on the taking edge, so a later change of the address
	// while read valid stands cannot disturb the data
	// read data select; registers hold only implemented bits
	wire [31:0] rd_value =
		({32{rsel_fn_one}}  & peripheral_function_enable_one) |
		({32{rsel_fn_two}}  & peripheral_function_enable_two) |
		({32{rsel_clk_one}} & peripheral_clock_gate_one);

	// next state of the read path
	wire next_rvalid = (s_axi_rvalid_o & ~s_axi_rready_i) | ar_take;

	// write address and data capture, either order
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
		end else begin
			aw_full <= next_aw_full;
			w_full  <= next_w_full;
		end
	end

	// strobes are kept with the data so a partial write merges later
	// payload holding, no reset needed behind the full flags
	always_ff @(posedge core_clk_i) begin
		if (aw_take) begin
			aw_addr <= s_axi_awaddr_i;
		end
		if (w_take) begin
			w_data <= s_axi_wdata_i;
			w_strb <= s_axi_wstrb_i;
		end
	end

	// ready flags: free slot and no response still pending
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
		end else begin
			s_axi_awready_o <= ~next_aw_full & ~next_bvalid;
			s_axi_wready_o  <= ~next_w_full & ~next_bvalid;
		end
	end

	// an unmapped write is still answered so the master never hangs
	// write response; unmapped address answers slave error
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= PECG_RESP_OKAY;
		end else begin
			s_axi_bvalid_o <= next_bvalid;
			if (do_write) begin
				s_axi_bresp_o <= wsel_hit ? PECG_RESP_OKAY
					: PECG_RESP_SLVERR;
			end
		end
	end

	// enable registers: all implemented bits on after reset
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			peripheral_function_enable_one <= PECG_RST_ALL_ON
				& mask_one;
			peripheral_function_enable_two <= PECG_RST_ALL_ON
				& mask_two;
			peripheral_clock_gate_one      <= PECG_RST_ALL_ON
				& mask_one;
		end else if (do_write) begin
			// only the addressed register takes the write
			if (wsel_fn_one) begin
				peripheral_function_enable_one <= merged_fn_one;
			end
			if (wsel_fn_two) begin
				peripheral_function_enable_two <= merged_fn_two;
			end
			if (wsel_clk_one) begin
				peripheral_clock_gate_one <= merged_clk_one;
			end
		end
	end

	// read address ready: one read under way at a time
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			s_axi_arready_o <= 1'b0;
		end else begin
			s_axi_arready_o <= ~next_rvalid;
		end
	end

	// read data and response, loaded when the address is taken
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h00000000;
			s_axi_rresp_o  <= PECG_RESP_OKAY;
		end else begin
			s_axi_rvalid_o <= next_rvalid;
			if (ar_take) begin
				// unmapped reads return zero with slave error
				s_axi_rdata_o <= rd_value;
				s_axi_rresp_o <= rsel_hit ? PECG_RESP_OKAY
					: PECG_RESP_SLVERR;
			end
		end
	end

	// each peripheral reset comes straight from a flop, so no decode
	// glitch of the bus logic can reach a peripheral as a reset pulse
	// resets for the first group follow the function enables
	pecg_rst_hold #(
		.WIDTH          (32)
	) u_rst_one (
		.core_clk_i     (core_clk_i),
		.rstn_i         (rstn_i),
		.fn_en_i        (peripheral_function_enable_one),
		.periph_rst_n_o (fn_one_rst_n_o)
	);

	// resets for the second group follow the function enables
	pecg_rst_hold #(
		.WIDTH          (32)
	) u_rst_two (
		.core_clk_i     (core_clk_i),
		.rstn_i         (rstn_i),
		.fn_en_i        (peripheral_function_enable_two),
		.periph_rst_n_o (fn_two_rst_n_o)
	);

	// the gate flop samples on the falling edge, so a write that lands
	// at a rising edge shows up as whole pulses from the next high phase
	// one glitch-free gate per clock-enable bit; reserved and
	// unimplemented bits hold a zero enable, so their clock stays low
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_gate
			pecg_clk_gate u_gate (
				.clk_i  (core_clk_i),
				.en_i   (peripheral_clock_gate_one[gi]),
				.gclk_o (gated_clk_one_o[gi])
			);
		end
	endgenerate

	// software must open a peripheral's clock before use; the block
	// does not tie the reset release to the clock enable
	// a peripheral whose clock is stopped keeps its state; clearing its
	// function enable as well is what returns it to a known state
endmodule
`default_nettype wire

// *** verif/pecg_top_properties.sv ***
// checker: bus timing and output properties of the enable block
`default_nettype none
module pecg_top_props
	import pecg_pkg::*;
(
	// clock and reset
	input wire logic        core_clk_i,
	input wire logic        rstn_i,
	// write channels
	input wire logic [31:0] s_axi_awaddr_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0]  s_axi_wstrb_i,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	// read channels
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// peripheral outputs
	input wire logic [31:0] fn_one_rst_n_o,
	input wire logic [31:0] fn_two_rst_n_o,
	input wire logic [31:0] gated_clk_one_o
);
	localparam logic [31:0] M1 = 32'h030F0F10; // implemented, group one
	localparam logic [31:0] M2 = 32'h00F30F33; // implemented, group two
	wire ar_hit; // read address names a register
	wire ar_ok;  // read address taken
	wire aw_ok;  // write address and data taken together
	assign ar_hit = (s_axi_araddr_i == PECG_FN_ONE_ADDR) ||
		(s_axi_araddr_i == PECG_FN_TWO_ADDR) ||
		(s_axi_araddr_i == PECG_CLK_ONE_ADDR);
	assign ar_ok = s_axi_arvalid_i && s_axi_arready_o;
	assign aw_ok = s_axi_awvalid_i && s_axi_awready_o &&
		s_axi_wvalid_i && s_axi_wready_o;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read data dropped early");
	chk_read_lat: assert property (ar_ok |=> s_axi_rvalid_o)
		else $error("read answer late");
	chk_write_lat: assert property (aw_ok |-> ##2 s_axi_bvalid_o)
		else $error("write answer late");
	chk_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address taken while busy");
	chk_w_block: assert property (s_axi_bvalid_o |->
		!s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while response pends");
	chk_unmapped_rd: assert property (ar_ok && !ar_hit |=>
		s_axi_rresp_o == PECG_RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read answered wrongly");
	chk_rsvd_low: assert property ((fn_one_rst_n_o & ~M1) == 32'h0 &&
		(fn_two_rst_n_o & ~M2) == 32'h0 && (gated_clk_one_o & ~M1) == 32'h0)
		else $error("unimplemented output bit active");
	chk_gate_low: assert property (gated_clk_one_o == 32'h0)
		else $error("gated clock high while source low");
	cov_write: cover property (aw_ok);
	cov_read: cover property (ar_ok);
	cov_bad_read: cover property (ar_ok && !ar_hit);
endmodule
bind pecg_top pecg_top_props chk (.*);
`default_nettype wire

// *** verif/testbench.sv ***
// testbench: register access and enable outputs over the bus
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import pecg_pkg::*;
	// bench-driven inputs
	logic        core_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0;
	logic [31:0] s_axi_araddr_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'h0;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
	logic        s_axi_rready_i = 1'b0;
	// design outputs
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o, fn_one_rst_n_o, fn_two_rst_n_o;
	logic [31:0] gated_clk_one_o;
	// bookkeeping
	int          error_cnt = 0;
	int          n_compared = 0;
	logic [31:0] rd;
	localparam logic [31:0] ADDR [3] = '{PECG_FN_ONE_ADDR,
		PECG_FN_TWO_ADDR, PECG_CLK_ONE_ADDR};
	localparam logic [31:0] MASK [3] = '{32'h030F0F10, 32'h00F30F33,
		32'h030F0F10};
	localparam logic [31:0] BAD [3] = '{32'h40000034, 32'h40000024,
		32'h4000002A};
	pecg_top uut (.*);
	// 10 MHz core clock
	always #50 core_clk_i = ~core_clk_i;
	// compare and count
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic conclude;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one bus write, address and data offered together
	task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s,
			input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge core_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= s;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (!done) begin
			@(posedge core_clk_i);
			if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) begin
				s_axi_awvalid_i <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) begin
				s_axi_wvalid_i <= 1'b0;
			end
			if (s_axi_bvalid_o === 1'b1) begin
				check("bresp", {30'h0, s_axi_bresp_o}, {30'h0, er});
				s_axi_bready_i <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// one bus read, data returned in d
	task automatic axi_read(input logic [31:0] a, input logic [1:0] er,
			output logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge core_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		while (!done) begin
			@(posedge core_clk_i);
			if (s_axi_arvalid_i && s_axi_arready_o === 1'b1) begin
				s_axi_arvalid_i <= 1'b0;
			end
			if (s_axi_rvalid_o === 1'b1) begin
				check("rresp", {30'h0, s_axi_rresp_o}, {30'h0, er});
				d = s_axi_rdata_o;
				s_axi_rready_i <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	// output belonging to register k, read in the clock's high phase
	function automatic logic [31:0] out_of(input int k);
		if (k == 0) return fn_one_rst_n_o;
		if (k == 1) return fn_two_rst_n_o;
		return gated_clk_one_o;
	endfunction
	// hang guard
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end
	// main sequence
	initial begin
		repeat (9) @(posedge core_clk_i);
		#25;
		check("reset held one", fn_one_rst_n_o, 32'h0);
		check("reset held two", fn_two_rst_n_o, 32'h0);
		@(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#25;
		for (int k = 0; k < 3; k++) begin
			check("output after reset", out_of(k), MASK[k]);
			axi_read(ADDR[k], PECG_RESP_OKAY, rd);
			check("register after reset", rd, MASK[k]);
		end
		// walk a single one through every bit of every register
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 32; i++) begin
				axi_write(ADDR[k], 32'h1 << i, 4'hF, PECG_RESP_OKAY);
				axi_read(ADDR[k], PECG_RESP_OKAY, rd);
				check("field map", rd, (32'h1 << i) & MASK[k]);
				#25;
				check("enable output", out_of(k), (32'h1 << i) & MASK[k]);
			end
			axi_write(ADDR[k], 32'hFFFFFFFF, 4'hF, PECG_RESP_OKAY);
			axi_read(ADDR[k], PECG_RESP_OKAY, rd);
			check("all enabled", rd, MASK[k]);
			#25;
			check("all outputs", out_of(k), MASK[k]);
		end
		// clear only byte lane one of the second register
		axi_write(ADDR[1], 32'h0, 4'h2, PECG_RESP_OKAY);
		axi_read(ADDR[1], PECG_RESP_OKAY, rd);
		check("lane write", rd, 32'h00F30033);
		#25;
		check("lane output", fn_two_rst_n_o, 32'h00F30033);
		// unmapped and misaligned places
		for (int j = 0; j < 3; j++) begin
			axi_write(BAD[j], 32'h0, 4'hF, PECG_RESP_SLVERR);
			axi_read(BAD[j], PECG_RESP_SLVERR, rd);
			check("unmapped read", rd, 32'h0);
		end
		axi_read(ADDR[0], PECG_RESP_OKAY, rd);
		check("untouched", rd, MASK[0]);
		// second reset in mid-run restores the defaults
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#25;
		check("output after second reset", fn_two_rst_n_o, MASK[1]);
		axi_read(ADDR[1], PECG_RESP_OKAY, rd);
		check("register after second reset", rd, MASK[1]);
		conclude();
	end
endmodule
`default_nettype wire
